// file: core/uart_status_control.sv
// Status and control logic of the serial transceiver with its two 4-deep buffers.
// Assumes external shifters that report completion and a synchronous AXI4-Lite master.
`timescale 1ns/10ps
module uart_status_control (
	input  wire logic                              sys_clk,
	input  wire logic                              rst,
	input  wire logic [uart_sc_pkg::ADDR_W-1:0]    awaddr,
	input  wire logic                              awvalid,
	output logic                                   awready,
	input  wire logic [uart_sc_pkg::DATA_W-1:0]    wdata,
	input  wire logic [3:0]                        wstrb,
	input  wire logic                              wvalid,
	output logic                                   wready,
	output logic [1:0]                             bresp,
	output logic                                   bvalid,
	input  wire logic                              bready,
	input  wire logic [uart_sc_pkg::ADDR_W-1:0]    araddr,
	input  wire logic                              arvalid,
	output logic                                   arready,
	output logic [uart_sc_pkg::DATA_W-1:0]         rdata,
	output logic [1:0]                             rresp,
	output logic                                   rvalid,
	input  wire logic                              rready,
	output logic [uart_sc_pkg::CHAR_W-1:0]         txChar,
	output logic                                   txCharBreak,
	output logic                                   txCharValid,
	input  wire logic                              txCharReady,
	input  wire logic                              txShifterBusy,
	input  wire logic                              txShifterDone,
	input  wire logic                              txLineBit,
	input  wire logic                              txIrBit,
	output logic                                   txAbort,
	output logic                                   serialOut,
	output logic                                   serialOutEn,
	input  wire logic [uart_sc_pkg::CHAR_W-1:0]    rxChar,
	input  wire logic                              rxCharParityErr,
	input  wire logic                              rxCharFrameErr,
	input  wire logic                              rxCharValid,
	input  wire logic                              rxActive,
	output logic                                   rxShiftFlush,
	output logic                                   rxAddressSeen,
	output logic                                   txIrq,
	output logic                                   rxIrq
);
	import uart_sc_pkg::*;

	logic [1:0]         txSelReg;
	logic               txInvReg;
	logic               breakReg;
	logic               txEnReg;
	logic [1:0]         rxSelReg;
	logic               addrEnReg;
	logic               overrunReg;
	logic               irEnReg;
	logic               nineBitReg;
	logic               highSpeedReg;
	logic               breakInFlightReg;
	logic [CHAR_W-1:0]  txMem [FIFO_DEPTH];
	logic [PTR_W-1:0]   txWrPtrReg;
	logic [PTR_W-1:0]   txRdPtrReg;
	logic [CNT_W-1:0]   txCountReg;
	logic [CHAR_W+1:0]  rxMem [FIFO_DEPTH];
	logic [PTR_W-1:0]   rxWrPtrReg;
	logic [PTR_W-1:0]   rxRdPtrReg;
	logic [CNT_W-1:0]   rxCountReg;
	logic [CNT_W-1:0]   rxCountNext;
	logic               serialOutReg;
	logic               serialOutNext;

	function automatic logic [CNT_W-1:0] stepCount(input logic [CNT_W-1:0] cnt,
		input logic up, input logic down);
		stepCount = cnt + {{(CNT_W-1){1'b0}}, up} - {{(CNT_W-1){1'b0}}, down};
	endfunction

	// Bus decode: a write needs both address and data, one write in flight at a time.
	wire wrFire  = awvalid & wvalid & ~bvalid;
	wire rdFire  = arvalid & ~rvalid;
	wire wrSc    = wrFire & (awaddr == OFF_SC);
	wire wrTx    = wrFire & (awaddr == OFF_TXDATA) & wstrb[0];
	wire wrMode  = wrFire & (awaddr == OFF_MODE);
	wire wrKnown = (awaddr == OFF_SC) | (awaddr == OFF_TXDATA) | (awaddr == OFF_MODE);
	wire rdKnown = (araddr == OFF_SC) | (araddr == OFF_RXDATA) | (araddr == OFF_MODE);
	wire rdRx    = rdFire & (araddr == OFF_RXDATA);

	assign awready = wrFire;
	assign wready  = wrFire;
	assign arready = rdFire;

	// Transmit buffer.
	wire txEmpty    = (txCountReg == '0);
	wire txFull     = (txCountReg == CNT_FULL);
	wire txAllEmpty = txEmpty & ~txShifterBusy;
	wire txPush     = wrTx & txEnReg & ~txFull;
	wire txPop      = txCharValid & txCharReady;
	assign txCharValid = txEnReg & ~txEmpty;
	assign txChar      = txMem[txRdPtrReg];
	assign txCharBreak = breakReg;
	assign txAbort     = ~txEnReg;

	// Receive buffer; address mode drops data characters and overrun freezes the buffer.
	wire addrMode  = addrEnReg & nineBitReg;
	wire rxWanted  = rxCharValid & ~(addrMode & ~rxChar[CHAR_W-1]);
	wire rxEmpty   = (rxCountReg == '0);
	wire rxFull    = (rxCountReg == CNT_FULL);
	wire overflow  = rxWanted & rxFull & ~overrunReg;
	wire rxPush    = rxWanted & ~rxFull & ~overrunReg;
	wire rxPop     = rdRx & ~rxEmpty;
	wire ovrClear  = wrSc & wstrb[0] & ~wdata[B_OVERRUN] & overrunReg & ~overflow;
	wire rxAvail   = ~rxEmpty;
	wire rxIdle    = ~rxActive;
	wire [CHAR_W+1:0] rxHead = rxMem[rxRdPtrReg];
	wire parityTop = rxAvail & rxHead[CHAR_W];
	wire frameTop  = rxAvail & rxHead[CHAR_W+1];
	assign rxCountNext = stepCount(rxCountReg, rxPush, rxPop);

	wire [15:0] scWord = {txSelReg[1], txInvReg, txSelReg[0], 1'b0, breakReg, txEnReg,
		txFull, txAllEmpty, rxSelReg, addrEnReg, rxIdle, parityTop, frameTop,
		overrunReg, rxAvail};
	wire [15:0] modeWord = {13'h0, highSpeedReg, nineBitReg, irEnReg};
	wire [15:0] rdWord   = (araddr == OFF_SC) ? scWord :
		(araddr == OFF_MODE) ? modeWord :
		(araddr == OFF_RXDATA) ? {7'h0, rxHead[CHAR_W-1:0]} : 16'h0;

	// Line level: the encoder counts only in sixteen-times mode.
	wire irActive = irEnReg & ~highSpeedReg;
	always_comb begin
		if (irActive) begin
			serialOutNext = txShifterBusy ? txIrBit : txInvReg;
		end else begin
			serialOutNext = txShifterBusy ? (txLineBit ^ txInvReg) : ~txInvReg;
		end
	end
	assign serialOut   = serialOutReg;
	assign serialOutEn = txEnReg;

	// Interrupt events.
	wire txIrqNext = (txSelReg == TXSEL_EACH) ? txPop :
		(txSelReg == TXSEL_EMPTY) ? (txPop & (txCountReg == 3'h1) & ~txPush) :
		(txSelReg == TXSEL_DONE) ? (txShifterDone & txEmpty & ~txPush) : 1'b0;
	wire rxIrqNext = ~rxSelReg[1] ? rxPush :
		(rxSelReg == RXSEL_3Q) ? (rxPush & (rxCountNext == CNT_3Q)) :
		(rxPush & (rxCountNext == CNT_FULL));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			txSelReg     <= '0;
			txInvReg     <= 1'b0;
			txEnReg      <= 1'b0;
			rxSelReg     <= '0;
			addrEnReg    <= 1'b0;
			irEnReg      <= 1'b0;
			nineBitReg   <= 1'b0;
			highSpeedReg <= 1'b0;
		end else begin
			if (wrSc & wstrb[1]) begin
				txSelReg <= {wdata[B_TXSEL1], wdata[B_TXSEL0]};
				txInvReg <= wdata[B_TXINV];
				txEnReg  <= wdata[B_TXEN];
			end
			if (wrSc & wstrb[0]) begin
				rxSelReg  <= wdata[B_RXSEL0+1:B_RXSEL0];
				addrEnReg <= wdata[B_ADDRDET];
			end
			if (wrMode & wstrb[0]) begin
				irEnReg      <= wdata[B_IRCODEC];
				nineBitReg   <= wdata[B_NINEBIT];
				highSpeedReg <= wdata[B_HIGHSPEED];
			end
		end
	end

	// Break bit: software sets it, hardware clears it when the break character finishes.
	wire breakDone = breakInFlightReg & txShifterDone;
	always_ff @(posedge sys_clk) begin
		if (rst | ~txEnReg) begin
			breakReg         <= 1'b0;
			breakInFlightReg <= 1'b0;
		end else begin
			if (wrSc & wstrb[1]) begin
				breakReg <= wdata[B_BREAK];
			end else if (breakDone) begin
				breakReg <= 1'b0;
			end
			if (txPop & breakReg) begin
				breakInFlightReg <= 1'b1;
			end else if (breakDone) begin
				breakInFlightReg <= 1'b0;
			end
		end
	end

	// Overrun: set wins over a clear arriving in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			overrunReg <= 1'b0;
		end else begin
			overrunReg <= overflow | (overrunReg & ~ovrClear);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst | ~txEnReg) begin
			txWrPtrReg <= '0;
			txRdPtrReg <= '0;
			txCountReg <= '0;
		end else begin
			txWrPtrReg <= txWrPtrReg + PTR_W'(txPush);
			txRdPtrReg <= txRdPtrReg + PTR_W'(txPop);
			txCountReg <= stepCount(txCountReg, txPush, txPop);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (txPush) begin
			txMem[txWrPtrReg] <= wdata[CHAR_W-1:0];
		end
		if (rxPush) begin
			rxMem[rxWrPtrReg] <= {rxCharFrameErr, rxCharParityErr, rxChar};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst | ovrClear) begin
			rxWrPtrReg <= '0;
			rxRdPtrReg <= '0;
			rxCountReg <= '0;
		end else begin
			rxWrPtrReg <= rxWrPtrReg + PTR_W'(rxPush);
			rxRdPtrReg <= rxRdPtrReg + PTR_W'(rxPop);
			rxCountReg <= rxCountNext;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serialOutReg  <= 1'b1;
			rxShiftFlush  <= 1'b0;
			rxAddressSeen <= 1'b0;
			txIrq         <= 1'b0;
			rxIrq         <= 1'b0;
		end else begin
			serialOutReg  <= serialOutNext;
			rxShiftFlush  <= ovrClear;
			rxAddressSeen <= rxPush & addrMode;
			txIrq         <= txIrqNext;
			rxIrq         <= rxIrqNext;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp  <= RESP_OKAY;
			rdata  <= '0;
		end else begin
			if (wrFire) begin
				bvalid <= 1'b1;
				bresp  <= wrKnown ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (rdFire) begin
				rvalid <= 1'b1;
				rresp  <= rdKnown ? RESP_OKAY : RESP_SLVERR;
				rdata  <= {16'h0, rdWord};
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	chk_idle_level_plain: assert property (@(posedge sys_clk) disable iff (rst)
		(!irActive && !txShifterBusy) |=> (serialOut == !$past(txInvReg)))
		else $error("Plain idle level wrong.");
	chk_idle_level_ir: assert property (@(posedge sys_clk) disable iff (rst)
		(irActive && !txShifterBusy) |=> (serialOut == $past(txInvReg)))
		else $error("Encoded idle level wrong.");
	chk_disable_flush: assert property (@(posedge sys_clk) disable iff (rst)
		!txEnReg |=> (txCountReg == '0) && !txCharValid)
		else $error("Transmit buffer not emptied when disabled.");
	chk_full_flag: assert property (@(posedge sys_clk) disable iff (rst)
		(wrTx && txFull && txEnReg && !txPop) |=> (txCountReg == CNT_FULL))
		else $error("Write accepted into a full buffer.");
	chk_rx_irq_full: assert property (@(posedge sys_clk) disable iff (rst)
		(rxSelReg == RXSEL_FULL && rxPush && rxCountReg == CNT_3Q && !rxPop) |=> rxIrq)
		else $error("Full receive interrupt missing.");
	chk_rx_irq_3q: assert property (@(posedge sys_clk) disable iff (rst)
		($past(rxSelReg) == RXSEL_3Q && rxIrq) |-> ($past(rxCountReg) == 3'h2 || $past(rxPop)))
		else $error("Three-quarter interrupt at wrong fill.");
	chk_overrun_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		(overrunReg && !(wrSc && wstrb[0] && !wdata[B_OVERRUN])) |=> overrunReg)
		else $error("Overrun flag dropped without a clear.");
	chk_overrun_flush: assert property (@(posedge sys_clk) disable iff (rst)
		ovrClear |=> (rxCountReg == '0) && rxShiftFlush && !overrunReg)
		else $error("Clearing overrun did not flush the receiver.");
	chk_overrun_freeze: assert property (@(posedge sys_clk) disable iff (rst)
		(overrunReg && !ovrClear && !rxPop) |=> $stable(rxCountReg))
		else $error("Receive buffer changed while overrun set.");
	chk_break_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(breakDone && !(wrSc && wstrb[1])) |=> !breakReg)
		else $error("Break request not cleared on completion.");
	chk_full_reached: assert property (@(posedge sys_clk) disable iff (rst)
		(txPush && !txPop && txCountReg == CNT_3Q) |=> txFull)
		else $error("Buffer-full flag missing at four characters.");
	chk_all_empty: assert property (@(posedge sys_clk) disable iff (rst)
		(txShifterBusy || !txEmpty) |-> !scWord[8])
		else $error("All-empty flag set while transmit work remains.");
	chk_rx_irq_any: assert property (@(posedge sys_clk) disable iff (rst)
		(!rxSelReg[1] && rxPush) |=> rxIrq)
		else $error("Per-character receive interrupt missing.");
	chk_addr_filter: assert property (@(posedge sys_clk) disable iff (rst)
		(addrMode && rxCharValid && !rxChar[CHAR_W-1]) |-> !rxPush)
		else $error("Data character buffered in address mode.");
	chk_rx_idle: assert property (@(posedge sys_clk) disable iff (rst)
		rxActive |-> !scWord[4])
		else $error("Receiver idle flag set while receiving.");
	chk_head_parity: assert property (@(posedge sys_clk) disable iff (rst)
		(rxPush && rxEmpty) |=> (scWord[3] == $past(rxCharParityErr)))
		else $error("Parity flag does not follow the head character.");
	chk_head_frame: assert property (@(posedge sys_clk) disable iff (rst)
		(rxPush && rxEmpty) |=> (scWord[2] == $past(rxCharFrameErr)))
		else $error("Framing flag does not follow the head character.");
	chk_overrun_set: assert property (@(posedge sys_clk) disable iff (rst)
		(rxWanted && rxFull && !overrunReg) |=> overrunReg)
		else $error("Overflow did not set the overrun flag.");
	chk_data_avail: assert property (@(posedge sys_clk) disable iff (rst)
		rxPush |=> scWord[0])
		else $error("Data-available flag missing after a transfer.");
	chk_bit12_zero: assert property (@(posedge sys_clk) disable iff (rst)
		(rdFire && araddr == OFF_SC) |=> !rdata[12])
		else $error("Unimplemented status bit read as one.");
	chk_tx_irq_each: assert property (@(posedge sys_clk) disable iff (rst)
		(txSelReg == TXSEL_EACH && txPop) |=> txIrq)
		else $error("Per-transfer transmit interrupt missing.");
	chk_ir_highspeed: assert property (@(posedge sys_clk) disable iff (rst)
		(irEnReg && highSpeedReg && !txShifterBusy) |=> (serialOut == !$past(txInvReg)))
		else $error("Encoder acted in high-speed mode.");
endmodule

// file: shared/uart_sc_pkg.sv
// Constants for the serial transceiver status and control block.
// Assumes a 32-bit AXI4-Lite master and external shift registers.
// How it works
// - Encoder off: idle line is low when polarity invert is 1, else high.
// - Encoder on: encoded idle is high when polarity invert is 1, else low.
// - Break request sends start, twelve zeros, stop; bit clears itself after.
// - Transmit enable drives the pin; disabling aborts and empties the buffer.
// - Buffer-full flag is 1 when no further character fits.
// - All-empty flag is 1 only when shifter and buffer are both empty.
// - Receive select 11 interrupts when a transfer leaves four characters.
// - Receive select 10 interrupts when a transfer leaves three characters.
// - Receive select 0x interrupts on every character transferred in.
// - Address detect in nine-bit mode treats bit 8 set as address.
// - Receiver idle flag reads 1 when idle, 0 while receiving.
// - Parity error flag belongs to the character at the buffer head.
// - Framing error flag belongs to the character at the buffer head.
// - Overrun flag set by overflow; software may clear, never set it.
// - Clearing a set overrun flag empties receive buffer and shift register.
// - Data-available flag is 1 while the receive buffer holds a character.
// - Bit 12 of the status and control register always reads zero.
// - Transmit select 00 per transfer, 10 on emptying, 01 when done.
// - Infrared encoder is effective only in the sixteen-times baud mode.
package uart_sc_pkg;
	localparam int         ADDR_W      = 4;
	localparam int         DATA_W      = 32;
	localparam int         CHAR_W      = 9;
	localparam int         FIFO_DEPTH  = 4;
	localparam int         PTR_W       = 2;
	localparam int         CNT_W       = 3;
	localparam logic [3:0] OFF_SC      = 4'h0;
	localparam logic [3:0] OFF_TXDATA  = 4'h4;
	localparam logic [3:0] OFF_RXDATA  = 4'h8;
	localparam logic [3:0] OFF_MODE    = 4'hc;
	localparam int         B_TXSEL1    = 15;
	localparam int         B_TXINV     = 14;
	localparam int         B_TXSEL0    = 13;
	localparam int         B_BREAK     = 11;
	localparam int         B_TXEN      = 10;
	localparam int         B_RXSEL0    = 6;
	localparam int         B_ADDRDET   = 5;
	localparam int         B_OVERRUN   = 1;
	localparam int         B_IRCODEC   = 0;
	localparam int         B_NINEBIT   = 1;
	localparam int         B_HIGHSPEED = 2;
	localparam logic [1:0] TXSEL_EACH  = 2'h0;
	localparam logic [1:0] TXSEL_DONE  = 2'h1;
	localparam logic [1:0] TXSEL_EMPTY = 2'h2;
	localparam logic [1:0] RXSEL_3Q    = 2'h2;
	localparam logic [1:0] RXSEL_FULL  = 2'h3;
	localparam logic [2:0] CNT_3Q      = 3'h3;
	localparam logic [2:0] CNT_FULL    = 3'h4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: sim/serial_node_model.sv
// Behavioural transmit and receive shifters beside the status block.
// Assumes the block's clock; the bench starts each received frame.
`timescale 1ns/10ps
module serial_node_model #(
	parameter int BITLEN = 10
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        txCharValid,
	input  wire logic        txAbort,
	input  wire logic        rxReq,
	input  wire logic [10:0] rxWord,
	input  wire logic        rxShiftFlush,
	output logic             txCharReady,
	output logic             txShifterBusy,
	output logic             txShifterDone,
	output logic             txLineBit,
	output logic             txIrBit,
	output logic [8:0]       rxChar,
	output logic             rxCharParityErr,
	output logic             rxCharFrameErr,
	output logic             rxCharValid,
	output logic             rxActive
);
	int          txCnt = 0;
	int          rxCnt = 0;
	logic [10:0] word  = '0;
	assign txCharReady   = !stall && txCnt == 0;
	assign txShifterBusy = txCnt != 0;
	assign txShifterDone = txCnt == 1;
	assign txLineBit     = txCnt == 0 || txCnt[0];
	assign txIrBit       = txCnt != 0 && !txCnt[0];
	assign rxActive      = rxCnt != 0;
	assign rxCharValid   = rxCnt == 1;
	// Outside the valid cycle the character lines carry the inverse, never a held value.
	assign {rxCharFrameErr, rxCharParityErr, rxChar} = rxCharValid ? word : ~word;
	always @(posedge sys_clk) begin
		txCnt <= rst || txAbort ? 0 : txCharValid && txCharReady ? BITLEN : txCnt - int'(txCnt != 0);
		rxCnt <= rst || rxShiftFlush ? 0 : rxReq ? BITLEN : rxCnt - int'(rxCnt != 0);
		if (rxReq)
			word <= rxWord;
	end
endmodule

// file: sim/tb.sv
// Self-checking bench for the serial transceiver status and control block.
// Assumes the design package, the block and the shifter model are compiled before it.
`timescale 1ns/10ps
module tb;
	import uart_sc_pkg::*;
	typedef struct {logic [3:0] a; logic [31:0] d, m, e; logic [1:0] r;} row_s;
	localparam logic [31:0] M = 32'hffff_f4e2;
	row_s rows [4] = '{'{4'h0, 32'h0000_ffff, M, 32'h0000_e4e0, RESP_OKAY},
		'{4'h0, 32'h0000_0000, M, 32'h0000_0000, RESP_OKAY},
		'{4'h0, 32'h0000_4442, M, 32'h0000_4440, RESP_OKAY},
		'{4'h2, 32'h0000_ffff, 32'h0, 32'h0, RESP_SLVERR}};
	int          txExp [4] = '{2, 1, 1, 0};
	int          rxExp [3] = '{4, 1, 1};
	logic        sys_clk = 1'b0, rst = 1'b1, stall = 1'b0, rxReq = 1'b0, idle;
	logic [3:0]  awaddr = '0, araddr = '0, wstrb = '0;
	logic [31:0] wdata = '0, rdata, rd, mode;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;
	logic [10:0] rxWord = '0;
	logic [8:0]  txChar, rxChar;
	logic        txCharBreak, txCharValid, txCharReady, txShifterBusy, txShifterDone, txLineBit;
	logic        txIrBit, txAbort, serialOut, serialOutEn, rxCharParityErr, rxCharFrameErr;
	logic        rxCharValid, rxActive, rxShiftFlush, rxAddressSeen, txIrq, rxIrq;
	int          n_mismatch = 0, n_tests = 0, cyc = 0, base = 0, txIrqs = 0, rxIrqs = 0;
	int          flushes = 0, seen = 0;
	uart_status_control u_uart_status_control (.*);
	serial_node_model #(.BITLEN(10)) u_serial_node_model (.*);
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		txIrqs += int'(txIrq === 1'b1);
		rxIrqs += int'(rxIrq === 1'b1);
		flushes += int'(rxShiftFlush === 1'b1);
		seen += int'(rxAddressSeen === 1'b1);
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		{awaddr, araddr, wdata, wstrb} <= {a, a, d, s};
		{awvalid, wvalid, bready} <= {3{w}};
		{arvalid, rready} <= {2{!w}};
		do @(posedge sys_clk); while ((w ? awready : arready) !== 1'b1);
		{awvalid, wvalid, arvalid} <= 3'b000;
		do @(posedge sys_clk); while ((w ? bvalid : rvalid) !== 1'b1);
		rd = rdata;
		rs = w ? bresp : rresp;
		{bready, rready} <= 2'b00;
		@(posedge sys_clk);
	endtask
	task automatic rx_send(input logic [10:0] w);
		rxWord <= w;
		rxReq <= 1'b1;
		@(posedge sys_clk);
		rxReq <= 1'b0;
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd & 32'h10, 32'h0, "receiver busy");
		repeat (12) @(posedge sys_clk);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd, 32'h0000_0110, "reset status");
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d, 4'hf);
			chk(32'(rs), 32'(rows[i].r), "write resp");
			bus(1'b0, rows[i].a, 32'h0, 4'h0);
			chk(rd & rows[i].m, rows[i].e, "readback");
			chk(32'(rs), 32'(rows[i].r), "read resp");
		end
		for (int k = 0; k < 6; k++) begin
			mode = k < 2 ? 32'h0 : k < 4 ? 32'h1 : 32'h5;
			idle = (k == 2 || k == 3) ? k[0] : !k[0];
			bus(1'b1, OFF_MODE, mode, 4'hf);
			bus(1'b1, OFF_SC, 32'h0400 | 32'(k[0]) << 14, 4'hf);
			chk(32'({serialOut, serialOutEn}), 32'({idle, 1'b1}), "idle line");
		end
		bus(1'b1, OFF_MODE, 32'h0, 4'hf);
		stall <= 1'b1;
		for (int c = 0; c < 5; c++) bus(1'b1, OFF_TXDATA, 32'h0a5 + c, 4'hf);
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd & 32'h0300, 32'h0200, "tx full");
		chk(32'(txChar), 32'h0a5, "tx head");
		bus(1'b1, OFF_SC, 32'h0000, 4'hf);
		chk(32'({serialOutEn, txAbort, txCharValid}), 32'h2, "tx abort");
		for (int s = 0; s < 4; s++) begin
			stall <= 1'b1;
			bus(1'b1, OFF_SC, 32'h0400 | 32'(s[1]) << 15 | 32'(s[0]) << 13, 4'hf);
			chk(32'(txCharValid), 32'h0, "tx buffer reset");
			bus(1'b1, OFF_TXDATA, 32'h0c3, 4'hf);
			bus(1'b1, OFF_TXDATA, 32'h13c, 4'hf);
			base = txIrqs;
			stall <= 1'b0;
			repeat (40) @(posedge sys_clk);
			chk(32'(txIrqs - base), 32'(txExp[s]), "tx irq count");
			bus(1'b0, OFF_SC, 32'h0, 4'h0);
			chk(rd & 32'h0300, 32'h0100, "tx drained");
		end
		bus(1'b1, OFF_SC, 32'h0c00, 4'hf);
		chk(32'(txCharBreak), 32'h1, "break flag");
		bus(1'b1, OFF_TXDATA, 32'h000, 4'hf);
		repeat (20) @(posedge sys_clk);
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd & 32'h0d00, 32'h0500, "break done");
		for (int s = 0; s < 3; s++) begin
			bus(1'b1, OFF_SC, 32'(s + 1) << 6, 4'hf);
			base = rxIrqs;
			for (int c = 0; c < 4; c++) rx_send(11'(c << 9) | (11'h030 + 11'(c)));
			chk(32'(rxIrqs - base), 32'(rxExp[s]), "rx irq count");
			for (int c = 0; c < 4; c++) begin
				bus(1'b0, OFF_SC, 32'h0, 4'h0);
				chk(rd & 32'h1d, 32'({c[0], c[1]}) << 2 | 32'h11, "rx head flags");
				bus(1'b0, OFF_RXDATA, 32'h0, 4'h0);
				chk(rd, 32'h030 + c, "rx data");
			end
			bus(1'b0, OFF_SC, 32'h0, 4'h0);
			chk(rd & 32'h1, 32'h0, "rx empty");
		end
		bus(1'b1, OFF_MODE, 32'h2, 4'hf);
		bus(1'b1, OFF_SC, 32'h0020, 4'hf);
		rx_send(11'h055);
		rx_send(11'h1aa);
		bus(1'b0, OFF_RXDATA, 32'h0, 4'h0);
		chk(rd, 32'h1aa, "address char");
		chk(32'(seen), 32'h1, "address pulse");
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd & 32'h1, 32'h0, "data skipped");
		bus(1'b1, OFF_MODE, 32'h0, 4'hf);
		bus(1'b1, OFF_SC, 32'h04e0, 4'hf);
		base = rxIrqs;
		for (int c = 0; c < 5; c++) rx_send(11'h040 + 11'(c));
		chk(32'(rxIrqs - base), 32'h1, "full irq once");
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd & 32'h3, 32'h3, "overrun set");
		base = rxIrqs;
		bus(1'b0, OFF_RXDATA, 32'h0, 4'h0);
		chk(rd, 32'h040, "overrun head kept");
		rx_send(11'h04f);
		chk(32'(rxIrqs - base), 32'h0, "overrun freeze");
		bus(1'b1, OFF_SC, 32'h0000, 4'h1);
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd & 32'h0403, 32'h0400, "overrun flush");
		chk(32'(flushes), 32'h1, "rx flush pulse");
		chk(32'(seen), 32'h1, "address pulse count");
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		bus(1'b0, OFF_SC, 32'h0, 4'h0);
		chk(rd, 32'h0000_0110, "mid-run reset");
		stop_test();
	end
endmodule
